// ===== design/scan_eq_pkg.sv
`default_nettype none
package scan_eq_pkg;
	localparam int NLANE = 2;                   // Physical lanes
	localparam int DECIM = 20;                  // One bit of every twenty analysed
	localparam int CNT_W = 20;                  // Mismatch counter width
	localparam int LEN_BASE = 16;               // Samples = LEN_BASE << length code
	// Scan mode codes
	localparam logic [3:0] MODE_MATCH = 4'h1;   // Counts matches, other modes below 8 mismatches
	localparam logic [3:0] MODE_AUTO = 4'h8;    // First self-adjusting mode
	localparam logic [3:0] MODE_INNER = 4'h8;
	localparam logic [3:0] MODE_OUTER = 4'h9;
	localparam logic [3:0] MODE_AVG = 4'ha;
	// Equalizer modes
	localparam logic [1:0] EQ_ADAPT = 2'h1;
	localparam logic [1:0] EQ_PRE = 2'h2;
	localparam logic [1:0] EQ_POST = 2'h3;
	// Timing, in unit intervals (one valid recovered bit each)
	localparam int FREEZE_UI = 48;
	localparam int ANALYSIS_UI = 150000;
	// Register byte offsets
	localparam logic [5:0] OFS_SCAN_CTRL = 6'h00;
	localparam logic [5:0] OFS_SCAN_CFG = 6'h04;
	localparam logic [5:0] OFS_SCAN_STAT = 6'h08;
	localparam logic [5:0] OFS_COUNT0 = 6'h0c;
	localparam logic [5:0] OFS_COUNT1 = 6'h10;
	localparam logic [5:0] OFS_BOUND = 6'h14;
	localparam logic [5:0] OFS_EQ_CTRL = 6'h18;
	localparam logic [5:0] OFS_EQ_STAT = 6'h1c;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h20;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h24;
	// Field positions
	localparam int F_RUN = 4;                   // SCAN_CTRL: [3:0] mode, run, clear
	localparam int F_CLR = 5;
	localparam int F_LEN = 8;                   // SCAN_CTRL [11:8] length code
	localparam int F_LANE_EN = 12;              // SCAN_CTRL [13:12] lane enables
	localparam int F_VOFS = 8;                  // SCAN_CFG: [4:0] bit sel, [15:8], [23:16]
	localparam int F_POFS = 16;
	localparam int F_FREEZE = 2;                // EQ_CTRL: [1:0] mode, freeze, rx enable
	localparam int F_LRE = 3;
	localparam int F_UNDER = 1;                 // EQ_STAT: over, under, busy, [13:8] level
	localparam int F_BUSY = 2;
	localparam int F_LEVEL = 8;
	localparam int IRQ_SCAN = 0;                // Interrupt bits
	localparam int IRQ_EQ = 1;
	// Reset values
	localparam logic [31:0] RST_SCAN_CTRL = 32'h0000_3000;
	localparam logic [1:0] RST_EQ_MODE = 2'h1;
	localparam logic [5:0] RST_LEVEL = 6'h20;
endpackage : scan_eq_pkg
`default_nettype wire

// ===== design/scan_lane.sv
`default_nettype none
// One lane of the eye-scan engine
module scan_lane (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Control from the register file
	input  wire logic              en,
	input  wire logic              run,
	input  wire logic              clear,
	input  wire logic [3:0]        mode,
	input  wire logic [7:0]        vofs_prog,
	input  wire logic [4:0]        bit_sel,
	input  wire logic [3:0]        len,
	// Recovered data and offset sampler
	input  wire logic              bit_valid,
	input  wire logic              rx_bit,
	input  wire logic              smp_bit,
	// Results
	output logic                   done_q,
	output logic [scan_eq_pkg::CNT_W-1:0] count_q,
	output logic [7:0]             bound_q,
	output logic [7:0]             vofs_q
);
	typedef enum logic [1:0] {S_IDLE, S_SCAN, S_FIN} st_t;
	st_t st_q;
	logic [4:0]  ph_q;                          // Decimation phase, 0..19
	logic [19:0] n_q;                           // Samples taken this run
	logic [7:0]  first_q, last_q;               // Boundary candidates
	logic        seen_q;                        // A mismatch was seen
	wire         auto_m = mode >= scan_eq_pkg::MODE_AUTO;
	wire         take = (st_q == S_SCAN) && bit_valid && (ph_q == bit_sel);
	wire         mis = rx_bit ^ smp_bit;
	wire         hit = (mode == scan_eq_pkg::MODE_MATCH) ? !mis : mis;
	wire  [19:0] target = 20'(scan_eq_pkg::LEN_BASE) << len;
	wire         last = take && (n_q + 20'h1 == target);
	wire  [8:0]  sum = {1'b0, first_q} + {1'b0, last_q};
	wire  [7:0]  bound = (mode == scan_eq_pkg::MODE_INNER) ? first_q :
	                     (mode == scan_eq_pkg::MODE_OUTER) ? last_q : sum[8:1];

	// Phase runs freely so the picked bit keeps its place in the group
	// Wraps only on a valid bit, so idle cycles never skip a position
	always_ff @(posedge clk) begin
		if (!nrst)
			ph_q <= 5'h0;
		else if (bit_valid)
			ph_q <= (ph_q == 5'(scan_eq_pkg::DECIM - 1)) ? 5'h0 : ph_q + 5'h1;
	end

	// Sequencing of a run
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= S_IDLE;
			done_q <= 1'b0;
			n_q <= 20'h0;
			seen_q <= 1'b0;
			first_q <= 8'h0;
			last_q <= 8'h0;
			bound_q <= 8'h0;
		end else begin
			case (st_q)
				S_IDLE: begin
					n_q <= 20'h0;
					seen_q <= 1'b0;
					if (run && en)
						st_q <= S_SCAN;
				end
				S_SCAN: begin
					if (!run) begin
						st_q <= S_IDLE;
					end else if (take) begin
						n_q <= n_q + 20'h1;
						if (auto_m && mis) begin
							if (!seen_q)
								first_q <= vofs_q;
							seen_q <= 1'b1;
							last_q <= vofs_q;
						end
						if (last)
							st_q <= S_FIN;
					end
				end
				S_FIN: begin
					done_q <= 1'b1;
					if (auto_m)
						bound_q <= seen_q ? bound : vofs_q;
					if (!run) begin
						done_q <= 1'b0;
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// Sampler offset: programmed below mode 8, swept otherwise
	always_ff @(posedge clk) begin
		if (!nrst)
			vofs_q <= 8'h0;
		else if (!auto_m)
			vofs_q <= vofs_prog;
		else if (st_q == S_IDLE)
			vofs_q <= 8'h0;
		else if (take)
			vofs_q <= vofs_q + 8'h1;
	end

	// Counter keeps adding across runs until cleared
	always_ff @(posedge clk) begin
		if (!nrst || clear)
			count_q <= '0;
		else if (take && !auto_m && hit)
			count_q <= count_q + 1'b1;
	end
endmodule : scan_lane
`default_nettype wire

// ===== design/scan_eq_top.sv
`default_nettype none
// Eye-scan and cursor analysis diagnostics with an Avalon-MM register port
module scan_eq_top #(
	parameter int ANALYSIS_UI = scan_eq_pkg::ANALYSIS_UI    // Shorten in simulation
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Avalon-MM slave
	input  wire logic [5:0]              address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [3:0]              byteenable,
	input  wire logic [31:0]             writedata,
	output logic [31:0]                  readdata,
	output logic                         waitrequest,
	// Receiver data, one valid bit per unit interval
	input  wire logic                    bit_valid,
	input  wire logic [1:0]              rx_bit,
	input  wire logic [1:0]              smp_bit,
	// Equalizer hints from the receiver
	input  wire logic                    adapt_up,
	input  wire logic                    adapt_dn,
	input  wire logic                    over_hint,
	input  wire logic                    under_hint,
	// Controls to the receiver
	output logic [15:0]                  scan_voltage_offset,
	output logic [7:0]                   scan_phase_offset,
	output logic                         link_receiver_enable,
	output logic [5:0]                   equalizer_level_readback,
	output logic                         equalizer_frozen,
	// Interrupt
	output logic                         irq
);
	localparam int NL = scan_eq_pkg::NLANE;

	// Register storage
	logic [31:0] scan_ctrl_q;                   // Mode, run, clear, length, lane enables
	logic [31:0] scan_cfg_q;                    // Bit select, voltage, phase offsets
	logic [1:0]  equalizer_mode_q;
	logic        equalizer_freeze_q;            // Software freeze request
	logic        lre_q;                         // Receiver enable bit
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic        ack_q;                         // High in the answer cycle
	logic        wait_q;                        // Registered waitrequest, low in the answer cycle
	logic [31:0] rdata_q;

	// Bus decode
	wire         req = read || write;
	wire         wr = write && ack_q;
	wire [31:0]  bmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
	                      {8{byteenable[1]}}, {8{byteenable[0]}}};
	wire         sel_sctl = address == scan_eq_pkg::OFS_SCAN_CTRL;
	wire         sel_scfg = address == scan_eq_pkg::OFS_SCAN_CFG;
	wire         sel_eqc = address == scan_eq_pkg::OFS_EQ_CTRL;
	wire         sel_ist = address == scan_eq_pkg::OFS_IRQ_STAT;
	wire         sel_imk = address == scan_eq_pkg::OFS_IRQ_MASK;

	// Byte-lane merge of write data into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] wd,
	                                      input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction : merge

	// Scan control fields
	wire [3:0]   es_mode = scan_ctrl_q[3:0];
	wire         scan_run = scan_ctrl_q[scan_eq_pkg::F_RUN];
	wire         mismatch_counter_clear = scan_ctrl_q[scan_eq_pkg::F_CLR];
	wire [3:0]   scan_sample_length = scan_ctrl_q[scan_eq_pkg::F_LEN +: 4];
	wire [NL-1:0] lane_en = scan_ctrl_q[scan_eq_pkg::F_LANE_EN +: NL];
	wire [4:0]   decimation_phase_select = scan_cfg_q[4:0];
	wire [7:0]   vofs_prog = scan_cfg_q[scan_eq_pkg::F_VOFS +: 8];

	// Per-lane results
	logic [NL-1:0] scan_done;
	logic [scan_eq_pkg::CNT_W-1:0] mismatch_counter [NL];
	logic [7:0]  found_voltage_boundary [NL];
	logic [7:0]  lane_vofs [NL];

	// Every enabled lane runs the same scan at once
	for (genvar l = 0; l < NL; l++) begin : g_lane
		scan_lane u_lane (
			.clk       (clk),
			.nrst      (nrst),
			.en        (lane_en[l] && lre_q),
			.run       (scan_run),
			.clear     (mismatch_counter_clear),
			.mode      (es_mode),
			.vofs_prog (vofs_prog),
			.bit_sel   (decimation_phase_select),
			.len       (scan_sample_length),
			.bit_valid (bit_valid),
			.rx_bit    (rx_bit[l]),
			.smp_bit   (smp_bit[l]),
			.done_q    (scan_done[l]),
			.count_q   (mismatch_counter[l]),
			.bound_q   (found_voltage_boundary[l]),
			.vofs_q    (lane_vofs[l])
		);
	end

	// Equalizer state
	typedef enum logic [1:0] {E_ADAPT, E_HOLD, E_ANALYSE} eq_st_t;
	eq_st_t      eq_st_q;
	logic        frz_act_q;                     // Freeze as applied to the equalizer
	logic [5:0]  level_q;
	logic [17:0] ui_q;                          // Unit intervals into analysis
	logic [17:0] over_n_q, under_n_q;           // Hint tallies
	logic        over_equalized_flag_q;
	logic        under_equalized_flag_q;
	wire         cursor_m = equalizer_mode_q == scan_eq_pkg::EQ_PRE ||
	                        equalizer_mode_q == scan_eq_pkg::EQ_POST;
	wire         release_ev = frz_act_q && !equalizer_freeze_q;
	wire         ana_end = (eq_st_q == E_ANALYSE) && bit_valid &&
	                       (ui_q == 18'(ANALYSIS_UI - 1));
	wire         all_done = &(scan_done | ~(lane_en & {NL{lre_q}}));
	logic        all_done_q;                    // For the done edge

	// Avalon answer: one wait cycle, then waitrequest low for a single cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			wait_q <= 1'b1;
		end else begin
			ack_q <= req && !ack_q;
			wait_q <= !(req && !ack_q);
		end
	end

	// Read mux, captured together with the answer
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (address)
			scan_eq_pkg::OFS_SCAN_CTRL: rd_mux = scan_ctrl_q;
			scan_eq_pkg::OFS_SCAN_CFG:  rd_mux = scan_cfg_q;
			scan_eq_pkg::OFS_SCAN_STAT: rd_mux = 32'(scan_done);
			scan_eq_pkg::OFS_COUNT0:    rd_mux = 32'(mismatch_counter[0]);
			scan_eq_pkg::OFS_COUNT1:    rd_mux = 32'(mismatch_counter[1]);
			scan_eq_pkg::OFS_BOUND:
				rd_mux = {16'h0, found_voltage_boundary[1], found_voltage_boundary[0]};
			scan_eq_pkg::OFS_EQ_CTRL:
				rd_mux = {28'h0, lre_q, equalizer_freeze_q, equalizer_mode_q};
			scan_eq_pkg::OFS_EQ_STAT:
				rd_mux = {18'h0, level_q, 5'h0, eq_st_q == E_ANALYSE,
				          under_equalized_flag_q, over_equalized_flag_q};
			scan_eq_pkg::OFS_IRQ_STAT:  rd_mux = {30'h0, irq_stat_q};
			scan_eq_pkg::OFS_IRQ_MASK:  rd_mux = {30'h0, irq_mask_q};
			default:                    rd_mux = 32'h0; // Unmapped reads as zero
		endcase
	end

	// Read data register
	always_ff @(posedge clk) begin
		if (!nrst)
			rdata_q <= 32'h0;
		else if (read && !ack_q)
			rdata_q <= rd_mux;
	end

	// Scan registers; run and clear are plain bits software toggles
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scan_ctrl_q <= scan_eq_pkg::RST_SCAN_CTRL;
			scan_cfg_q <= 32'h0;
		end else begin
			if (wr && sel_sctl)
				scan_ctrl_q <= merge(scan_ctrl_q, writedata, bmask);
			if (wr && sel_scfg)
				scan_cfg_q <= merge(scan_cfg_q, writedata, bmask);
		end
	end

	// Equalizer control; the two-step write order is left to software
	always_ff @(posedge clk) begin
		if (!nrst) begin
			equalizer_mode_q <= scan_eq_pkg::RST_EQ_MODE;
			equalizer_freeze_q <= 1'b0;
			lre_q <= 1'b0;
		end else if (wr && sel_eqc && byteenable[0]) begin
			equalizer_mode_q <= writedata[1:0];
			equalizer_freeze_q <= writedata[scan_eq_pkg::F_FREEZE];
			lre_q <= writedata[scan_eq_pkg::F_LRE];
		end
	end

	// Freeze reaches the equalizer one cycle later, far inside 48 UI
	always_ff @(posedge clk) begin
		if (!nrst)
			frz_act_q <= 1'b0;
		else
			frz_act_q <= equalizer_freeze_q;
	end

	// Adaptive level moves only in mode 1 while unfrozen and receiving
	always_ff @(posedge clk) begin
		if (!nrst)
			level_q <= scan_eq_pkg::RST_LEVEL;
		else if (eq_st_q == E_ADAPT && lre_q && bit_valid &&
		         equalizer_mode_q == scan_eq_pkg::EQ_ADAPT) begin
			if (adapt_up && !adapt_dn && level_q != 6'h3f)
				level_q <= level_q + 6'h1;
			else if (adapt_dn && !adapt_up && level_q != 6'h00)
				level_q <= level_q - 6'h1;
		end
	end

	// Equalizer sequencing: adapt, hold, cursor analysis
	always_ff @(posedge clk) begin
		if (!nrst) begin
			eq_st_q <= E_ADAPT;
		end else begin
			case (eq_st_q)
				E_ADAPT: if (frz_act_q) eq_st_q <= E_HOLD;
				E_HOLD: begin
					// Mode 1 with freeze low resumes even after an unfrozen analysis
					if (release_ev && cursor_m)
						eq_st_q <= E_ANALYSE;
					else if (!frz_act_q && !cursor_m)
						eq_st_q <= E_ADAPT;
				end
				E_ANALYSE: begin
					if (frz_act_q || ana_end || !cursor_m)
						eq_st_q <= E_HOLD; // Level stays locked after analysis
				end
				default: eq_st_q <= E_ADAPT;
			endcase
		end
	end

	// Analysis window counts only valid bits, so slow recovery stretches it
	always_ff @(posedge clk) begin
		if (!nrst || eq_st_q != E_ANALYSE) begin
			ui_q <= 18'h0;
			over_n_q <= 18'h0;
			under_n_q <= 18'h0;
		end else if (bit_valid) begin
			ui_q <= ui_q + 18'h1;
			over_n_q <= over_n_q + 18'(over_hint);
			under_n_q <= under_n_q + 18'(under_hint);
		end
	end

	// Result flags; freeze forces both low
	always_ff @(posedge clk) begin
		if (!nrst || frz_act_q) begin
			over_equalized_flag_q <= 1'b0;
			under_equalized_flag_q <= 1'b0;
		end else if (ana_end) begin
			over_equalized_flag_q <= over_n_q > under_n_q;
			under_equalized_flag_q <= under_n_q > over_n_q;
		end
	end

	// Interrupt status: set beats a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
			all_done_q <= 1'b0;
		end else begin
			all_done_q <= all_done && scan_run;
			irq_stat_q[scan_eq_pkg::IRQ_SCAN] <= (all_done && scan_run && !all_done_q) ||
				(irq_stat_q[scan_eq_pkg::IRQ_SCAN] &&
				 !(wr && sel_ist && byteenable[0] && writedata[scan_eq_pkg::IRQ_SCAN]));
			irq_stat_q[scan_eq_pkg::IRQ_EQ] <= ana_end ||
				(irq_stat_q[scan_eq_pkg::IRQ_EQ] &&
				 !(wr && sel_ist && byteenable[0] && writedata[scan_eq_pkg::IRQ_EQ]));
			if (wr && sel_imk && byteenable[0])
				irq_mask_q <= writedata[1:0];
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scan_voltage_offset <= 16'h0;
			scan_phase_offset <= 8'h0;
			link_receiver_enable <= 1'b0;
			equalizer_level_readback <= scan_eq_pkg::RST_LEVEL;
			equalizer_frozen <= 1'b0;
			irq <= 1'b0;
		end else begin
			scan_voltage_offset <= {lane_vofs[1], lane_vofs[0]};
			scan_phase_offset <= scan_cfg_q[scan_eq_pkg::F_POFS +: 8];
			link_receiver_enable <= lre_q;
			equalizer_level_readback <= level_q;
			equalizer_frozen <= eq_st_q != E_ADAPT;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign readdata = rdata_q;
	assign waitrequest = wait_q;
endmodule : scan_eq_top
`default_nettype wire

// ===== verif/scan_eq_sva.sv
`default_nettype none
// Watches the register port and receiver controls of the diagnostics block
module scan_eq_sva (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register bus
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	// Receiver side
	input  wire logic [15:0] scan_voltage_offset,
	input  wire logic [7:0]  scan_phase_offset,
	input  wire logic        link_receiver_enable,
	input  wire logic [5:0]  equalizer_level_readback,
	input  wire logic        equalizer_frozen,
	input  wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic        ack;     // Write accepted at this edge
	logic        ack_eq;  // Accepted write to the equalizer control
	logic [31:0] wd_q;    // Data of the last accepted write
	logic [3:0]  mode_q;  // Scan mode last written
	logic [1:0]  mask_q;  // Interrupt mask last written
	logic [2:0]  frz_q;   // Cycles since freeze was set, saturating, 0 when released
	assign ack = write && !waitrequest;
	assign ack_eq = ack && address == scan_eq_pkg::OFS_EQ_CTRL && byteenable[0];
	// Shadows of software writes; a shadow avoids sampling data the master already dropped
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wd_q <= 32'h0;
			mode_q <= 4'h0;
			mask_q <= 2'h0;
		end else if (ack) begin
			wd_q <= writedata;
			if (address == scan_eq_pkg::OFS_SCAN_CTRL && byteenable[0])
				mode_q <= writedata[3:0];
			if (address == scan_eq_pkg::OFS_IRQ_MASK && byteenable[0])
				mask_q <= writedata[1:0];
		end
	end
	// Age of the freeze request
	always_ff @(posedge clk) begin
		if (!nrst)
			frz_q <= 3'h0;
		else if (ack_eq)
			frz_q <= {2'h0, writedata[scan_eq_pkg::F_FREEZE]};
		else if (frz_q != 3'h0 && frz_q != 3'h7)
			frz_q <= frz_q + 3'h1;
	end
	a_read_answer: assert property (read && waitrequest |=> !waitrequest)
		else $error("read not answered in one cycle");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	a_vofs_prog: assert property (ack && address == scan_eq_pkg::OFS_SCAN_CFG && byteenable[1]
		&& mode_q < scan_eq_pkg::MODE_AUTO |-> ##[1:3] scan_voltage_offset == {2{wd_q[15:8]}})
		else $error("programmed voltage offset not applied");
	a_pofs_prog: assert property (ack && address == scan_eq_pkg::OFS_SCAN_CFG && byteenable[2]
		|-> ##[1:2] scan_phase_offset == wd_q[23:16])
		else $error("phase offset not applied");
	a_lre_copy: assert property (ack_eq |-> ##[1:2] link_receiver_enable == wd_q[3])
		else $error("receiver enable not applied");
	a_freeze_act: assert property (ack_eq && writedata[2] |-> ##[1:4] equalizer_frozen)
		else $error("freeze not acted on");
	a_freeze_flags: assert property (read && !waitrequest
		&& address == scan_eq_pkg::OFS_EQ_STAT && frz_q >= 3'h5 |-> readdata[1:0] == 2'b00)
		else $error("flags high while frozen");
	a_level_hold: assert property (equalizer_frozen && $past(equalizer_frozen)
		&& $past(equalizer_frozen, 2) |-> $stable(equalizer_level_readback))
		else $error("level moved while frozen");
	a_adapt_back: assert property (ack_eq && !writedata[2] && writedata[1:0] == 2'h1
		|-> ##[1:4] !equalizer_frozen)
		else $error("adaptation not resumed");
	a_irq_masked: assert property (irq |-> (mask_q | $past(mask_q)) != 2'h0)
		else $error("interrupt with all sources masked");
	c_irq: cover property ($rose(irq));
	c_freeze: cover property (ack_eq && writedata[2]);
	c_done: cover property (read && !waitrequest && address == scan_eq_pkg::OFS_SCAN_STAT
		&& readdata[1:0] == 2'b11);
endmodule : scan_eq_sva
bind scan_eq_top scan_eq_sva i_sva (.clk, .nrst, .address, .read, .write, .byteenable,
	.writedata, .readdata, .waitrequest, .scan_voltage_offset, .scan_phase_offset,
	.link_receiver_enable, .equalizer_level_readback, .equalizer_frozen, .irq);
`default_nettype wire

// ===== verif/link_tx.sv
`default_nettype none
// Far-end transmitter as seen through the receiver: bit stream and hints
module link_tx (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Commands from the bench
	input  wire logic [1:0] err_mask,
	input  wire logic [1:0] eq_bias,
	// Stream into the block
	output logic            bit_valid,
	output logic [1:0]      rx_bit,
	output logic [1:0]      smp_bit,
	output logic            adapt_up,
	output logic            adapt_dn,
	output logic            over_hint,
	output logic            under_hint
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] lfsr_q;  // Pattern source, fixed start so runs repeat
	// Pseudo-random pattern, one new bit each cycle, lane 1 a cycle behind lane 0
	always_ff @(posedge clk) begin
		if (!nrst)
			lfsr_q <= 7'h01;
		else
			lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
	end
	assign bit_valid = nrst;                    // Full recovery activity
	assign rx_bit = lfsr_q[1:0];                // Generic random stimulus
	assign smp_bit = lfsr_q[1:0] ^ err_mask;    // Offset sampler disagrees where told
	assign adapt_up = lfsr_q[0];                // Level takes a pseudo-random walk, one step per bit
	assign adapt_dn = !lfsr_q[0];
	assign over_hint = eq_bias[0];              // Cursor tally direction
	assign under_hint = eq_bias[1];
endmodule : link_tx
`default_nettype wire

// ===== verif/scan_eq_top_bench.sv
`default_nettype none
// Self-checking bench for the scan and cursor analysis block
module scan_eq_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;       // 200 MHz
	logic        nrst = 1'b0;      // Sync reset, active low
	logic [5:0]  address = 6'h00;  // Bus request
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [3:0]  byteenable = 4'hf;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest, bit_valid, adapt_up, adapt_dn, over_hint, under_hint;
	logic        lre, frozen, irq;
	logic [1:0]  rx_bit, smp_bit;
	logic [1:0]  err_mask = 2'h0;  // Lanes whose offset sampler disagrees
	logic [1:0]  eq_bias = 2'h0;   // Cursor hint direction
	logic [15:0] vofs;
	logic [7:0]  pofs;
	logic [5:0]  level;
	logic [31:0] q;                // Last word read
	int          n_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;          // Cycle count for latency checks
	int          el;
	always #2.5 clk = !clk;
	always @(posedge clk) cyc <= cyc + 1;
	scan_eq_top #(.ANALYSIS_UI(40)) i_dut (.clk, .nrst, .address, .read, .write, .byteenable,
		.writedata, .readdata, .waitrequest, .bit_valid, .rx_bit, .smp_bit, .adapt_up,
		.adapt_dn, .over_hint, .under_hint, .scan_voltage_offset(vofs),
		.scan_phase_offset(pofs), .link_receiver_enable(lre),
		.equalizer_level_readback(level), .equalizer_frozen(frozen), .irq);
	link_tx i_tx (.clk, .nrst, .err_mask, .eq_bias, .bit_valid, .rx_bit, .smp_bit, .adapt_up,
		.adapt_dn, .over_hint, .under_hint);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// One transfer, held until waitrequest is seen low; a hang is left to the watchdog
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rd(input logic [5:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Reads until any masked bit is set; the watchdog bounds it
	task poll(input logic [5:0] a, input logic [31:0] m);
		do begin
			rd(a);
		end while ((q & m) === 32'h0);
	endtask : poll
	// Lets registered outputs settle away from the edge
	task gap;
		repeat (3) @(posedge clk);
		#1;
	endtask : gap
	task print_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// One scan run with optional counter clear, then run written back to 0
	task scan(input logic [31:0] ctl, input logic clr, input logic [1:0] ln);
		if (clr) begin
			wr(scan_eq_pkg::OFS_SCAN_CTRL, ctl | 32'h20);
			wr(scan_eq_pkg::OFS_SCAN_CTRL, ctl);
		end
		el = cyc;
		wr(scan_eq_pkg::OFS_SCAN_CTRL, ctl | 32'h10);
		poll(scan_eq_pkg::OFS_SCAN_STAT, 32'h3);
		el = cyc - el;
		gap;
		rd(scan_eq_pkg::OFS_SCAN_STAT);
		chk(q, {30'h0, ln});
		wr(scan_eq_pkg::OFS_SCAN_CTRL, ctl);
		rd(scan_eq_pkg::OFS_SCAN_STAT);
		chk(q, 32'h0);
	endtask : scan
	task t_reset;
		rd(scan_eq_pkg::OFS_SCAN_CTRL);
		chk(q, scan_eq_pkg::RST_SCAN_CTRL);
		rd(scan_eq_pkg::OFS_EQ_STAT);
		chk(q, {18'h0, scan_eq_pkg::RST_LEVEL, 8'h00});
		chk({26'h0, level}, {26'h0, scan_eq_pkg::RST_LEVEL});
		wr(6'h3c, 32'hffff_ffff);
		rd(6'h3c);
		chk(q, 32'h0);
	endtask : t_reset
	// Mismatch count, decimation timing, interrupt, accumulation
	task t_count;
		wr(scan_eq_pkg::OFS_EQ_CTRL, 32'h9);
		wr(scan_eq_pkg::OFS_IRQ_MASK, 32'h3);
		wr(scan_eq_pkg::OFS_SCAN_CFG, 32'h0033_5a13);
		gap;
		chk({16'h0, vofs}, 32'h5a5a);
		chk({24'h0, pofs}, 32'h33);
		@(posedge clk) err_mask <= 2'b01;
		scan(32'h3000, 1'b1, 2'b11);
		chk({31'h0, el >= 300 && el <= 360}, 32'h1);
		rd(scan_eq_pkg::OFS_COUNT0);
		chk(q, 32'h10);
		rd(scan_eq_pkg::OFS_COUNT1);
		chk(q, 32'h0);
		gap;
		chk({31'h0, irq}, 32'h1);
		wr(scan_eq_pkg::OFS_IRQ_MASK, 32'h0);
		gap;
		chk({31'h0, irq}, 32'h0);
		wr(scan_eq_pkg::OFS_IRQ_MASK, 32'h3);
		wr(scan_eq_pkg::OFS_IRQ_STAT, 32'h1);
		gap;
		chk({31'h0, irq}, 32'h0);
		scan(32'h3000, 1'b0, 2'b11);
		rd(scan_eq_pkg::OFS_COUNT0);
		chk(q, 32'h20);
	endtask : t_count
	// Match counting on one enabled lane, then boundary modes
	task t_modes;
		@(posedge clk) err_mask <= 2'b10;
		scan(32'h1001, 1'b1, 2'b01);
		rd(scan_eq_pkg::OFS_COUNT0);
		chk(q, 32'h10);
		@(posedge clk) err_mask <= 2'b11;
		scan(32'h3008, 1'b0, 2'b11);
		rd(scan_eq_pkg::OFS_BOUND);
		chk(q, 32'h0);
		scan(32'h3009, 1'b0, 2'b11);
		rd(scan_eq_pkg::OFS_BOUND);
		chk(q, 32'h0f0f);
		scan(32'h300a, 1'b0, 2'b11);
		rd(scan_eq_pkg::OFS_BOUND);
		chk(q, 32'h0707);
	endtask : t_modes
	// One cursor analysis pass from a frozen equalizer
	task eq_step(input logic [1:0] m, input logic [1:0] b);
		@(posedge clk) eq_bias <= b;
		wr(scan_eq_pkg::OFS_EQ_CTRL, {28'h3, m});
		el = cyc;
		wr(scan_eq_pkg::OFS_EQ_CTRL, {28'h2, m});
		poll(scan_eq_pkg::OFS_EQ_STAT, 32'h3);
		chk({31'h0, cyc - el <= 70}, 32'h1);
		chk(q & 32'h3, {30'h0, b});
		chk({31'h0, frozen}, 32'h1);
		rd(scan_eq_pkg::OFS_IRQ_STAT);
		chk(q & 32'h2, 32'h2);
		wr(scan_eq_pkg::OFS_IRQ_STAT, 32'h2);
		wr(scan_eq_pkg::OFS_EQ_CTRL, {28'h3, m});
		gap;
		rd(scan_eq_pkg::OFS_EQ_STAT);
		chk(q & 32'h3, 32'h0);
	endtask : eq_step
	task t_eq;
		wr(scan_eq_pkg::OFS_EQ_CTRL, 32'hd);
		gap;
		chk({30'h0, lre, frozen}, 32'h3);
		eq_step(scan_eq_pkg::EQ_PRE, 2'b01);
		eq_step(scan_eq_pkg::EQ_POST, 2'b10);
		wr(scan_eq_pkg::OFS_EQ_CTRL, 32'hd);
		wr(scan_eq_pkg::OFS_EQ_CTRL, 32'h9);
		gap;
		chk({31'h0, frozen}, 32'h0);
	endtask : t_eq
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_count;
		t_modes;
		t_eq;
		print_verdict;
	end
	// Watchdog well past the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict;
	end
endmodule : scan_eq_top_bench
`default_nettype wire
